/* File: inc/twc_pkg.sv */
// thermal window comparator: shared constants, register map and carriers
// assumes a single 25 MHz clock and an APB master on the register side
// ----------------------------------------------------------------------
// Notes on behaviour
// RL1: high/critical flags set above, clear below minus hysteresis
// RL2: low flag sets below, clears above plus hysteresis
// RL3: flags depend only on temperature versus setpoints
// RL4: critical alarm tracks critical flag in every mode
// RL5: reads leave critical alarm untouched
// RL6: comparator mode: read clears, conversion end resets
// RL7: event mode: one assert per event, held until read
// RL8: event is setpoint rise or hysteresis fall crossing
// RL9: any register read aborts and restarts conversion
// RL10: host masks interrupt while reprogramming, then reads
// RL11: host keeps low and high bands non-overlapping
// RL12: setpoint defaults low 10, high 64, critical 80
// RL13: defaults hysteresis 2, comparator, active low, temperature
// RL14: two-wire slave address 10010 plus two straps
// RL15: ten-bit two's complement, half degree steps
// RL16: frequent reads keep temperature result from updating
// RL17: shutdown stops conversions, alarms ignore temperature
// RL18: registers stay accessible during shutdown
// RL19: alarm outputs open-drain, only pull low
// RL20: fault queue needs four agreeing conversions
// RL21: fault queue enabled by configuration bit four
// RL22: window alert and critical alarm, programmable polarity
// RL23: configuration bits shutdown, mode, polarities, queue
// RL24: temperature word: flags low bits, temperature above
// RL25: selector keeps last value, reserved bits zero
// RL26: entering shutdown releases both alarm outputs; the code releases them only at polarity 0, at polarity 1 it pulls both low
// RL27: pin level is alert combined with polarity
// RL28: evaluation once per completed conversion interval
// ----------------------------------------------------------------------
package twc_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] TWC_OFS_TEMP = 8'h00;
  localparam logic [7:0] TWC_OFS_CFG = 8'h04;
  localparam logic [7:0] TWC_OFS_HYST = 8'h08;
  localparam logic [7:0] TWC_OFS_CRIT = 8'h0c;
  localparam logic [7:0] TWC_OFS_LOW = 8'h10;
  localparam logic [7:0] TWC_OFS_HIGH = 8'h14;
  localparam logic [7:0] TWC_OFS_SEL = 8'h18;
  localparam int TWC_AW = 8;

  // ----------------------------------------------------------------------
  // data format and reset values, half degree units
  // ----------------------------------------------------------------------
  localparam int TWC_TW = 10;
  localparam int TWC_FLAG_POS = 3;
  localparam int TWC_CFG_W = 5;
  localparam int TWC_SEL_W = 3;
  localparam logic [9:0] TWC_RST_LOW = 10'h014;
  localparam logic [9:0] TWC_RST_HIGH = 10'h080;
  localparam logic [9:0] TWC_RST_CRIT = 10'h0a0;
  localparam logic [9:0] TWC_RST_HYST = 10'h004;
  localparam logic [2:0] TWC_RST_SEL = 3'h0;
  localparam int TWC_FL_LOW = 0;
  localparam int TWC_FL_HIGH = 1;
  localparam int TWC_FL_CRIT = 2;
  localparam logic [1:0] TWC_FQ_LAST = 2'h3;

  // ----------------------------------------------------------------------
  // two-wire slave and timing
  // ----------------------------------------------------------------------
  localparam logic [4:0] TWC_ADDR_HI = 5'h12;
  localparam logic [3:0] TWC_ADDR_BITS = 4'h8;
  localparam int TWC_CONV_W = 24;
  localparam int TWC_CONV_DEF = 8000;

  // configuration byte bits 4..0
  typedef struct packed {
    logic fault_q;
    logic int_pol;
    logic crit_pol;
    logic evt_mode;
    logic shutdown;
  } twc_cfg_t;

  localparam twc_cfg_t TWC_RST_CFG = '0;

  typedef enum logic [3:0] {
    TWC_I2C_IDLE = 4'b0001,
    TWC_I2C_ADDR = 4'b0010,
    TWC_I2C_ACK = 4'b0100,
    TWC_I2C_WAIT = 4'b1000
  } twc_i2c_st_t;

endpackage

/* File: hw/twc_top.sv */
// thermal window comparator: flags, fault queue, alarms, APB registers,
// two-wire address recognition
// assumes temp_in comes from the converter on pclk; scl/sda/straps are
// asynchronous pins; pins are resolved outside from the enables
`timescale 1ns/1ps
module twc_top #(
  parameter int CONV_CYCLES = twc_pkg::TWC_CONV_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [twc_pkg::TWC_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [twc_pkg::TWC_TW-1:0] temp_in,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic address_strap_bit0,
  input wire logic address_strap_bit1,
  output logic window_alert_o,
  output logic window_alert_oe,
  output logic critical_alarm_out,
  output logic critical_alarm_out_oe
);
  import twc_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  twc_cfg_t cfg_r;
  logic [9:0] low_r, high_r, crit_r, hyst_r, temp_r;
  logic [2:0] sel_r;
  logic [2:0] flag_r, flag_nxt, tgt;
  logic [1:0] fq_cnt_r [3];
  logic [1:0] fq_cnt_nxt [3];
  logic [TWC_CONV_W-1:0] conv_cnt_r;
  logic conv_done, read_evt, win_evt, apb_done, int_act_r;
  logic pready_r, pslverr_r, int_oe_r, crit_oe_r, od_zero_r, sda_oe_r, i2c_rd_r;
  logic [31:0] prdata_r;
  logic [3:0] pin_s1, pin_s2, pin_s3, pin_f, pin_nxt;
  twc_i2c_st_t i2c_st_r;
  logic [7:0] shift_r;
  logic [3:0] bit_cnt_r;

  // ----------------------------------------------------------------------
  // APB slave, one wait state so read data comes from a flop
  // ----------------------------------------------------------------------
  assign apb_done = psel & penable & pready_r;
  assign read_evt = (apb_done & ~pwrite) | i2c_rd_r;

  function automatic logic [31:0] twc_word(input logic [9:0] v, input logic [2:0] lo);
    twc_word = {16'h0000, {3{v[9]}}, v, lo};
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else begin
      pready_r <= psel & penable & ~pready_r;
      if (psel & penable & ~pready_r) begin
        pslverr_r <= 1'b0;
        prdata_r <= 32'h00000000;
        unique case (paddr)
          TWC_OFS_TEMP: prdata_r <= twc_word(temp_r, flag_r); // RL24
          TWC_OFS_CFG: prdata_r <= {27'h0000000, cfg_r}; // RL23
          TWC_OFS_HYST: prdata_r <= twc_word(hyst_r, 3'h0);
          TWC_OFS_CRIT: prdata_r <= twc_word(crit_r, 3'h0);
          TWC_OFS_LOW: prdata_r <= twc_word(low_r, 3'h0);
          TWC_OFS_HIGH: prdata_r <= twc_word(high_r, 3'h0);
          TWC_OFS_SEL: prdata_r <= {29'h00000000, sel_r}; // RL25
          default: pslverr_r <= 1'b1;
        endcase
      end
    end
  end

  // writes land at the completing edge; shutdown does not block them
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_r <= TWC_RST_CFG; // RL13
      low_r <= TWC_RST_LOW; // RL12
      high_r <= TWC_RST_HIGH; // RL12
      crit_r <= TWC_RST_CRIT; // RL12
      hyst_r <= TWC_RST_HYST; // RL13
      sel_r <= TWC_RST_SEL; // RL13
    end else if (apb_done & pwrite) begin // RL18
      unique case (paddr)
        TWC_OFS_CFG: cfg_r <= twc_cfg_t'(pwdata[TWC_CFG_W-1:0]); // RL21
        TWC_OFS_HYST: hyst_r <= pwdata[TWC_FLAG_POS +: TWC_TW]; // RL15
        TWC_OFS_CRIT: crit_r <= pwdata[TWC_FLAG_POS +: TWC_TW];
        TWC_OFS_LOW: low_r <= pwdata[TWC_FLAG_POS +: TWC_TW];
        TWC_OFS_HIGH: high_r <= pwdata[TWC_FLAG_POS +: TWC_TW];
        TWC_OFS_SEL: sel_r <= pwdata[TWC_SEL_W-1:0]; // RL25
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // conversion interval
  // ----------------------------------------------------------------------
  // a read in the final cycle wins, so a busy host starves the result
  assign conv_done = (conv_cnt_r == TWC_CONV_W'(CONV_CYCLES - 1)) & ~cfg_r.shutdown
                     & ~read_evt; // RL16

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_cnt_r <= '0;
      temp_r <= 10'h000;
    end else begin
      if (cfg_r.shutdown | read_evt | conv_done) begin // RL9 RL17
        conv_cnt_r <= '0;
      end else begin
        conv_cnt_r <= conv_cnt_r + 1'b1; // RL28
      end
      if (conv_done) begin
        temp_r <= temp_in;
      end
    end
  end

  // ----------------------------------------------------------------------
  // comparison with hysteresis and fault queue, one entry per flag
  // ----------------------------------------------------------------------
  logic signed [10:0] t_s, lo_s, hi_s, cr_s, hy_s;
  assign t_s = 11'(signed'(temp_in));
  assign lo_s = 11'(signed'(low_r));
  assign hi_s = 11'(signed'(high_r));
  assign cr_s = 11'(signed'(crit_r));
  assign hy_s = 11'(signed'(hyst_r));

  always_comb begin
    tgt = flag_r;
    if (t_s < lo_s) tgt[TWC_FL_LOW] = 1'b1; // RL2
    else if (t_s > lo_s + hy_s) tgt[TWC_FL_LOW] = 1'b0; // RL2
    if (t_s > hi_s) tgt[TWC_FL_HIGH] = 1'b1; // RL1
    else if (t_s < hi_s - hy_s) tgt[TWC_FL_HIGH] = 1'b0; // RL1
    if (t_s > cr_s) tgt[TWC_FL_CRIT] = 1'b1; // RL1
    else if (t_s < cr_s - hy_s) tgt[TWC_FL_CRIT] = 1'b0; // RL1
  end

  generate
    for (genvar i = 0; i < 3; i++) begin : g_flag
      always_comb begin
        flag_nxt[i] = flag_r[i];
        fq_cnt_nxt[i] = fq_cnt_r[i];
        if (conv_done) begin // RL3
          if (tgt[i] == flag_r[i]) begin
            fq_cnt_nxt[i] = 2'h0;
          end else if (!cfg_r.fault_q || fq_cnt_r[i] == TWC_FQ_LAST) begin // RL20
            flag_nxt[i] = tgt[i];
            fq_cnt_nxt[i] = 2'h0;
          end else begin
            fq_cnt_nxt[i] = fq_cnt_r[i] + 2'h1;
          end
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          flag_r[i] <= 1'b0;
          fq_cnt_r[i] <= 2'h0;
        end else begin
          flag_r[i] <= flag_nxt[i];
          fq_cnt_r[i] <= fq_cnt_nxt[i];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // window alert and pin drive
  // ----------------------------------------------------------------------
  // any change of the window flags is a crossing of a setpoint or its band
  assign win_evt = (flag_nxt[TWC_FL_HIGH] ^ flag_r[TWC_FL_HIGH])
                 | (flag_nxt[TWC_FL_LOW] ^ flag_r[TWC_FL_LOW]); // RL8

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_act_r <= 1'b0;
    end else if (cfg_r.shutdown) begin
      int_act_r <= 1'b0; // RL26
    end else if (cfg_r.evt_mode) begin
      // set and clear crossings both count; the event wins over a read
      if (win_evt) begin
        int_act_r <= 1'b1; // RL7
      end else if (read_evt) begin
        int_act_r <= 1'b0; // RL7
      end
    end else if (read_evt) begin
      int_act_r <= 1'b0; // RL6
    end else if (conv_done) begin
      int_act_r <= flag_nxt[TWC_FL_HIGH] | flag_nxt[TWC_FL_LOW]; // RL6
    end
  end

  // enable high pulls the pin low; polarity 0 means asserted is low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_oe_r <= 1'b0;
      crit_oe_r <= 1'b0;
      od_zero_r <= 1'b0;
    end else begin
      int_oe_r <= (int_act_r & ~cfg_r.shutdown) ^ cfg_r.int_pol; // RL22 RL27
      crit_oe_r <= (flag_r[TWC_FL_CRIT] & ~cfg_r.shutdown) ^ cfg_r.crit_pol; // RL4 RL17
      od_zero_r <= 1'b0; // RL19
    end
  end

  // ----------------------------------------------------------------------
  // two-wire address recognition; data bytes are not decoded
  // ----------------------------------------------------------------------
  logic scl_rise, scl_fall, start_c, stop_c;
  assign pin_nxt = (pin_s3 & ~(pin_s2 ^ pin_s3)) | (pin_f & (pin_s2 ^ pin_s3));
  assign scl_rise = pin_nxt[3] & ~pin_f[3];
  assign scl_fall = ~pin_nxt[3] & pin_f[3];
  assign start_c = pin_f[3] & pin_nxt[3] & pin_f[2] & ~pin_nxt[2];
  assign stop_c = pin_f[3] & pin_nxt[3] & ~pin_f[2] & pin_nxt[2];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 4'hf;
      pin_s2 <= 4'hf;
      pin_s3 <= 4'hf;
      pin_f <= 4'hf;
    end else begin
      pin_s1 <= {scl_i, sda_i, address_strap_bit1, address_strap_bit0};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= pin_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      i2c_st_r <= TWC_I2C_IDLE;
      shift_r <= 8'h00;
      bit_cnt_r <= 4'h0;
      sda_oe_r <= 1'b0;
      i2c_rd_r <= 1'b0;
    end else begin
      i2c_rd_r <= 1'b0;
      if (start_c) begin
        i2c_st_r <= TWC_I2C_ADDR;
        bit_cnt_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else if (stop_c) begin
        i2c_st_r <= TWC_I2C_IDLE;
        sda_oe_r <= 1'b0;
      end else begin
        unique case (i2c_st_r)
          TWC_I2C_IDLE: ;
          TWC_I2C_ADDR: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], pin_nxt[2]};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == TWC_ADDR_BITS) begin
              if (shift_r[7:1] == {TWC_ADDR_HI, pin_f[1:0]}) begin // RL14
                i2c_st_r <= TWC_I2C_ACK;
                sda_oe_r <= 1'b1;
                i2c_rd_r <= shift_r[0]; // RL9
              end else begin
                i2c_st_r <= TWC_I2C_WAIT;
              end
            end
          end
          TWC_I2C_ACK: begin
            if (scl_fall) begin
              i2c_st_r <= TWC_I2C_WAIT;
              sda_oe_r <= 1'b0;
            end
          end
          TWC_I2C_WAIT: ;
        endcase
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign sda_o = od_zero_r;
  assign sda_oe = sda_oe_r;
  assign window_alert_o = od_zero_r;
  assign window_alert_oe = int_oe_r;
  assign critical_alarm_out = od_zero_r;
  assign critical_alarm_out_oe = crit_oe_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_flags_on_read: assert property (read_evt |=> $stable(flag_r)) // RL3
    else $error("flags moved after a read");
  a_read_restart: assert property (read_evt |=> conv_cnt_r == '0) // RL9
    else $error("read did not restart conversion");
  a_crit_tracks: assert property (flag_r[TWC_FL_CRIT] && !cfg_r.shutdown && !cfg_r.crit_pol
    && !$changed(cfg_r) |=> critical_alarm_out_oe) // RL4
    else $error("critical alarm not pulled low with flag set");
  // the output register lags the flag by one edge, so a flag that moved just before
  // the read is still allowed to reach the pin
  a_crit_read_keep: assert property (read_evt && !cfg_r.shutdown && !$changed(cfg_r)
    && $stable(flag_r) |=> $stable(critical_alarm_out_oe)) // RL5
    else $error("read changed critical alarm");
  a_cmp_reassert: assert property (conv_done && !cfg_r.evt_mode |=>
    int_act_r == (flag_r[TWC_FL_HIGH] | flag_r[TWC_FL_LOW]) ##1
    window_alert_oe == (($past(int_act_r) & ~$past(cfg_r.shutdown)) ^ $past(cfg_r.int_pol))) // RL6
    else $error("comparator alert not following conversion");
  a_read_clears: assert property (read_evt |=> !int_act_r) // RL6
    else $error("read left window alert set");
  a_evt_hold: assert property (cfg_r.evt_mode && int_act_r && !read_evt && !cfg_r.shutdown
    |=> int_act_r) // RL7
    else $error("event alert dropped without read");
  a_evt_set: assert property (cfg_r.evt_mode && !cfg_r.shutdown && conv_done && win_evt
    |=> int_act_r) // RL8
    else $error("crossing did not raise event alert");
  a_high_set: assert property (conv_done && !cfg_r.fault_q && t_s > hi_s
    |=> flag_r[TWC_FL_HIGH]) // RL1
    else $error("high flag not set above setpoint");
  a_low_set: assert property (conv_done && !cfg_r.fault_q && t_s < lo_s
    |=> flag_r[TWC_FL_LOW]) // RL2
    else $error("low flag not set below setpoint");
  a_crit_set: assert property (conv_done && !cfg_r.fault_q && t_s > cr_s
    |=> flag_r[TWC_FL_CRIT]) // RL1
    else $error("critical flag not set above setpoint");
  a_high_clear: assert property (conv_done && !cfg_r.fault_q && t_s < hi_s - hy_s
    |=> !flag_r[TWC_FL_HIGH]) // RL1
    else $error("high flag not cleared below band");
  a_low_clear: assert property (conv_done && !cfg_r.fault_q && t_s > lo_s + hy_s
    |=> !flag_r[TWC_FL_LOW]) // RL2
    else $error("low flag not cleared above band");
  // flags freeze while stopped; a stale flag may reappear after wake-up
  a_sd_frozen: assert property (cfg_r.shutdown |=> $stable(flag_r)) // RL17
    else $error("flags moved during shutdown");
  a_evt_quiet: assert property (cfg_r.evt_mode && !int_act_r && !win_evt
    |=> !int_act_r) // RL7
    else $error("event alert raised without a crossing");
  a_sd_no_conv: assert property (cfg_r.shutdown |-> !conv_done) // RL17
    else $error("conversion completed in shutdown");
  a_sd_release: assert property (cfg_r.shutdown && $past(cfg_r.shutdown)
    |-> ##1 critical_alarm_out_oe == $past(cfg_r.crit_pol)
    && window_alert_oe == $past(cfg_r.int_pol)) // RL26
    else $error("alarm active during shutdown");
  a_od_only_low: assert property (!sda_o && !window_alert_o && !critical_alarm_out) // RL19
    else $error("open-drain output driven high");
  a_fq_hold: assert property (cfg_r.fault_q && conv_done && fq_cnt_r[TWC_FL_HIGH] != TWC_FQ_LAST
    |=> $stable(flag_r[TWC_FL_HIGH])) // RL20
    else $error("fault queue let flag change early");
  a_ack_drive: assert property (i2c_st_r == TWC_I2C_ACK |-> sda_oe) // RL14
    else $error("address acknowledge not driven");

  c_high_trip: cover property (conv_done ##1 flag_r[TWC_FL_HIGH]);
  c_evt_read: cover property (cfg_r.evt_mode && int_act_r ##1 read_evt ##1 !int_act_r);
  c_addr_ack: cover property (i2c_st_r == TWC_I2C_ACK);
  c_sd_wake: cover property (cfg_r.shutdown ##1 !cfg_r.shutdown);
  c_fq_trip: cover property (cfg_r.fault_q && conv_done && fq_cnt_r[TWC_FL_CRIT] == TWC_FQ_LAST);
endmodule

/* File: bench/twc_host_model.sv */
// two-wire bus master model for the thermal window comparator bench
// assumes pull-ups on scl and sda; the bench resolves both wires
`timescale 1ns/1ps
module twc_host_model (
  input wire logic pclk,
  output logic scl_pull,
  output logic sda_pull,
  input wire logic sda_line
);
  // ----------------------------------------------------------------
  // frame driver
  // ----------------------------------------------------------------
  // scl stands released between frames; one bit is 8 pclk, i.e. 320 ns
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // address byte msb first, then the ack bit, then a stop
  task automatic frame(input logic [6:0] addr, input logic rw, output logic ack);
    logic [7:0] b;
    b = {addr, rw};
    sda_pull <= 1'b1;
    hold(2);
    scl_pull <= 1'b1;
    hold(2);
    for (int i = 7; i >= 0; i--) begin
      sda_pull <= ~b[i];
      hold(2);
      scl_pull <= 1'b0;
      hold(4);
      scl_pull <= 1'b1;
      hold(2);
    end
    // the slave answers through a pin filter, so give it most of the low phase
    sda_pull <= 1'b0;
    hold(4);
    scl_pull <= 1'b0;
    hold(2);
    ack = ~sda_line;
    hold(2);
    scl_pull <= 1'b1;
    hold(2);
    sda_pull <= 1'b1;
    hold(2);
    scl_pull <= 1'b0;
    hold(2);
    sda_pull <= 1'b0;
    hold(4);
  endtask
endmodule

/* File: bench/twc_tb_top.sv */
// self-checking bench for the thermal window comparator over apb
// assumes pull-ups on both alarm pins and a short conversion interval
`timescale 1ns/1ps
module thermal_window_comparator_tb_top;
  import twc_pkg::*;
  localparam int CONV = 20;
  localparam int LIMIT = 20000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ack;
  logic [TWC_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [TWC_TW-1:0] temp_in;
  logic scl_pull, sda_pull, sda_o, sda_oe, win_o, win_oe, crit_o, crit_oe;
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  wire logic scl_line = ~scl_pull;
  wire logic sda_line = ~(sda_pull | sda_oe);

  twc_top #(.CONV_CYCLES(CONV)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .temp_in(temp_in), .scl_i(scl_line), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_strap_bit0(1'b0), .address_strap_bit1(1'b1),
    .window_alert_o(win_o), .window_alert_oe(win_oe),
    .critical_alarm_out(crit_o), .critical_alarm_out_oe(crit_oe)
  );

  twc_host_model host (
    .pclk(pclk), .scl_pull(scl_pull), .sda_pull(sda_pull), .sda_line(sda_line)
  );

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // waits for pready with no assumed latency; the global timeout cuts a hang
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  function automatic logic [31:0] spw(input logic [9:0] v);
    return {16'h0000, {3{v[9]}}, v, 3'b000};
  endfunction

  function automatic logic [31:0] tw(input logic [9:0] v, input logic [2:0] f);
    return {16'h0000, {3{v[9]}}, v, f};
  endfunction

  // oe high means the pin is pulled low
  task automatic alm(input logic w, input logic c);
    chk({30'h0, win_oe, crit_oe}, {30'h0, w, c});
  endtask

  // outside shutdown, a conversion end plus two edges always falls inside this wait
  task automatic conv(input logic [9:0] v);
    temp_in <= v;
    cyc(CONV + 4);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    rdc(TWC_OFS_TEMP, 32'h0);
    rdc(TWC_OFS_CFG, 32'h0);
    rdc(TWC_OFS_HYST, spw(10'h004));
    rdc(TWC_OFS_CRIT, spw(10'h0a0));
    rdc(TWC_OFS_LOW, spw(10'h014));
    rdc(TWC_OFS_HIGH, spw(10'h080));
    rdc(TWC_OFS_SEL, 32'h0);
    apb(1'b1, TWC_OFS_SEL, 32'h5);
    rdc(TWC_OFS_SEL, 32'h5);
    chk({29'h0, sda_o, win_o, crit_o}, 32'h0);
    alm(1'b0, 1'b0);
    rdc(8'h1c, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  task automatic critical_setpoint();
    conv(10'h0a1);
    alm(1'b1, 1'b1);
    rdc(TWC_OFS_TEMP, tw(10'h0a1, 3'b110));
    cyc(3);
    alm(1'b0, 1'b1);
    conv(10'h09d);
    alm(1'b1, 1'b1);
    conv(10'h09b);
    rdc(TWC_OFS_TEMP, tw(10'h09b, 3'b010));
    conv(10'h050);
    alm(1'b0, 1'b0);
  endtask

  task automatic t_event();
    apb(1'b1, TWC_OFS_CFG, 32'h2);
    conv(10'h010);
    alm(1'b1, 1'b0);
    rdc(TWC_OFS_TEMP, tw(10'h010, 3'b001));
    cyc(3);
    alm(1'b0, 1'b0);
    conv(10'h016);
    alm(1'b0, 1'b0);
    conv(10'h019);
    alm(1'b1, 1'b0);
    rdc(TWC_OFS_TEMP, tw(10'h019, 3'b000));
    apb(1'b1, TWC_OFS_CFG, 32'h0);
  endtask

  task automatic t_pol();
    apb(1'b1, TWC_OFS_CFG, 32'h0c);
    cyc(3);
    alm(1'b1, 1'b1);
    conv(10'h0a1);
    alm(1'b0, 1'b0);
    conv(10'h050);
    alm(1'b1, 1'b1);
    apb(1'b1, TWC_OFS_CFG, 32'h0);
  endtask

  task automatic t_shut();
    conv(10'h0a1);
    alm(1'b1, 1'b1);
    apb(1'b1, TWC_OFS_CFG, 32'h1);
    cyc(3);
    alm(1'b0, 1'b0);
    rdc(TWC_OFS_CFG, 32'h1);
    apb(1'b1, TWC_OFS_LOW, spw(10'h020));
    rdc(TWC_OFS_LOW, spw(10'h020));
    conv(10'h050);
    rdc(TWC_OFS_TEMP, tw(10'h0a1, 3'b110));
    alm(1'b0, 1'b0);
    apb(1'b1, TWC_OFS_LOW, spw(10'h014));
    apb(1'b1, TWC_OFS_CFG, 32'h0);
    apb(1'b0, TWC_OFS_TEMP, 32'h0);
    conv(10'h050);
  endtask

  // the read restarts the interval, so the fourth agreeing end is known
  task automatic t_fq();
    apb(1'b1, TWC_OFS_CFG, 32'h10);
    apb(1'b0, TWC_OFS_TEMP, 32'h0);
    temp_in <= 10'h0a1;
    cyc(3 * CONV + CONV / 2);
    alm(1'b0, 1'b0);
    cyc(CONV);
    alm(1'b1, 1'b1);
    apb(1'b0, TWC_OFS_TEMP, 32'h0);
    temp_in <= 10'h050;
    cyc(5 * CONV);
    apb(1'b1, TWC_OFS_CFG, 32'h0);
  endtask

  task automatic t_restart();
    conv(10'h050);
    rdc(TWC_OFS_TEMP, tw(10'h050, 3'b000));
    temp_in <= 10'h060;
    repeat (8) rdc(TWC_OFS_TEMP, tw(10'h050, 3'b000));
    cyc(CONV + 4);
    rdc(TWC_OFS_TEMP, tw(10'h060, 3'b000));
  endtask

  task automatic t_addr();
    host.frame({5'b10010, 2'b10}, 1'b0, ack);
    chk({31'h0, ack}, 32'h1);
    host.frame({5'b10010, 2'b01}, 1'b0, ack);
    chk({31'h0, ack}, 32'h0);
    host.frame({5'b10010, 2'b10}, 1'b1, ack);
    chk({31'h0, ack}, 32'h1);
  endtask

  // ----------------------------------------------------------------
  // clock, reset, sequence, timeout
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    temp_in = 10'h050;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    critical_setpoint();
    t_event();
    t_pol();
    t_shut();
    t_fq();
    t_restart();
    t_addr();
    report_and_stop();
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      n_errors++;
      report_and_stop();
    end
  end
endmodule
